// ### src/sensor_regs_pkg.sv
// Constants, types and helpers shared by the sensor register map blocks
package sensor_regs_pkg;

  localparam int NCH   = 14;
  localparam int NSEL  = 10;
  localparam int NSLOT = 20;
  localparam int CH_PA = 2;

  // Protocol addresses count from 0: register number minus one
  localparam logic [15:0] STATUS_ADDR = 16'h0260;
  localparam logic [15:0] WIN_FIRST   = 16'h0BB8;
  localparam logic [15:0] WIN_LAST    = 16'h0BCB;
  localparam logic [15:0] SEL_FIRST   = 16'h1770;
  localparam logic [15:0] SEL_LAST    = 16'h1779;
  localparam logic [15:0] SEL_RESET   = 16'h0000;

  localparam logic [7:0] FC_RD_HOLD  = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_MULTI = 8'h10;
  localparam logic [7:0] EXC_FUNC    = 8'h01;
  localparam logic [7:0] EXC_ADDR    = 8'h02;

  localparam logic [31:0] FLOAT_NAN = 32'h7FC00000;
  localparam logic [15:0] INT_ERR   = 16'h8000;

  // Status flag positions
  localparam int ST_NOT_ADJ     = 0;
  localparam int ST_PRESS_FAULT = 1;
  localparam int ST_DISP_COMM   = 2;
  localparam int ST_AZ_FAIL     = 3;
  localparam int ST_BITS        = 4;

  // First word of each float pair, and the integer twin, per channel
  localparam logic [15:0] FLOAT_BASE [NCH] = '{
    16'h04BA, 16'h04BC, 16'h04BE, 16'h04C0, 16'h04C2, 16'h0410, 16'h0412,
    16'h041E, 16'h0420, 16'h0422, 16'h049C, 16'h0432, 16'h0434, 16'h0436};
  localparam logic [15:0] INT_ADDR [NCH] = '{
    16'h1009, 16'h100A, 16'h100B, 16'h100C, 16'h100D, 16'h0FB4, 16'h0FB5,
    16'h0FBB, 16'h0FBC, 16'h0FBD, 16'h0FFA, 16'h0FC5, 16'h0FC6, 16'h0FC7};

  typedef enum logic [2:0] {
    SRC_NONE, SRC_FLO, SRC_FHI, SRC_INT, SRC_STAT
  } src_kind_t;

  typedef struct packed {src_kind_t kind; logic [3:0] idx;} src_t;
  typedef struct packed {
    logic valid; logic [7:0] func; logic [15:0] addr; logic [15:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic valid; logic err; logic [7:0] exc; logic [15:0] rdata;
  } reg_rsp_t;
  typedef struct packed {logic [31:0] fval; logic [15:0] ival;} meas_t;
  typedef struct packed {
    logic [31:0] flo; logic [31:0] fhi; logic [15:0] ilo; logic [15:0] ihi;
  } range_t;
  typedef meas_t meas_arr_t [NCH];

  // Which measurement or status word a protocol address names
  function automatic src_t classify(input logic [15:0] a);
    src_t s;
    s = '{kind: SRC_NONE, idx: 4'h0};
    if (a == STATUS_ADDR) s.kind = SRC_STAT;
    for (int i = 0; i < NCH; i++) begin
      if (a == FLOAT_BASE[i]) s = '{kind: SRC_FLO, idx: 4'(i)};
      if (a == FLOAT_BASE[i] + 16'h0001) s = '{kind: SRC_FHI, idx: 4'(i)};
      if (a == INT_ADDR[i]) s = '{kind: SRC_INT, idx: 4'(i)};
    end
    return s;
  endfunction

  // Maps an IEEE754 word to an unsigned key that orders like the value
  function automatic logic [31:0] fkey(input logic [31:0] f);
    return f[31] ? ~f : {1'b1, f[30:0]};
  endfunction

endpackage

// ### src/meas_clamp.sv
// One measurement channel: range clamp and fault substitution
`timescale 1ns/1ps
`default_nettype none
module meas_clamp (
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  input  wire sensor_regs_pkg::meas_t  raw,
  input  wire sensor_regs_pkg::range_t lim,
  input  wire logic                    crit_error,
  output var  sensor_regs_pkg::meas_t  meas_q
);
  import sensor_regs_pkg::*;

  meas_t meas_next;

  ////////////////////////////////////////////////////////////////////////
  // Clamp in the ordered-key domain so negative floats compare right
  always_comb begin
    meas_next = raw;
    if (fkey(raw.fval) < fkey(lim.flo)) meas_next.fval = lim.flo;
    if (fkey(raw.fval) > fkey(lim.fhi)) meas_next.fval = lim.fhi;
    if ($signed(raw.ival) < $signed(lim.ilo)) meas_next.ival = lim.ilo;
    if ($signed(raw.ival) > $signed(lim.ihi)) meas_next.ival = lim.ihi;
    if (crit_error) begin
      meas_next = '{fval: FLOAT_NAN, ival: INT_ERR};
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) meas_q <= '0;
    else meas_q <= meas_next;
  end

  ////////////////////////////////////////////////////////////////////////
  crit_subst_a: assert property (@(posedge mclk) disable iff (!nrst)
    crit_error |=> meas_q.fval == FLOAT_NAN && meas_q.ival == INT_ERR)
    else $error("fault values not substituted");

  int_clamp_a: assert property (@(posedge mclk) disable iff (!nrst)
    (!crit_error && $signed(lim.ilo) <= $signed(lim.ihi)) |=>
      ($signed(meas_q.ival) >= $signed($past(lim.ilo)) &&
       $signed(meas_q.ival) <= $signed($past(lim.ihi))))
    else $error("integer value outside range");

endmodule
`default_nettype wire

// ### src/custom_slot_map.sv
// Packs the ten selector words into the twenty-slot read window
`timescale 1ns/1ps
`default_nettype none
module custom_slot_map (
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic [15:0]           sel [sensor_regs_pkg::NSEL],
  output var  sensor_regs_pkg::src_t slot [sensor_regs_pkg::NSLOT]
);
  import sensor_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Empty or unknown selectors are skipped; later ones move up
  always_comb begin
    int    pos;
    src_t  s;
    pos = 0;
    s   = '{kind: SRC_NONE, idx: 4'h0};
    for (int k = 0; k < NSLOT; k++) slot[k] = '{kind: SRC_NONE, idx: 4'h0};
    for (int i = 0; i < NSEL; i++) begin
      s = classify(sel[i]);
      if (s.kind == SRC_FLO && pos < NSLOT - 1) begin
        slot[pos]     = s;
        slot[pos + 1] = '{kind: SRC_FHI, idx: s.idx};
        pos = pos + 2;
      end else if (s.kind != SRC_NONE && s.kind != SRC_FLO && pos < NSLOT) begin
        slot[pos] = s;
        pos = pos + 1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  float_pair_a: assert property (@(posedge mclk) disable iff (!nrst)
    classify(sel[0]).kind == SRC_FLO |->
      slot[0].kind == SRC_FLO && slot[1].kind == SRC_FHI &&
      slot[1].idx == classify(sel[0]).idx)
    else $error("float source not spread over two slots");

endmodule
`default_nettype wire

// ### src/sensor_modbus_register_map.sv
// Register map seen by the serial bus master: measurements, status, custom window
`timescale 1ns/1ps
`default_nettype none
module sensor_modbus_register_map (
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  input  wire sensor_regs_pkg::reg_req_t req,
  output var  sensor_regs_pkg::reg_rsp_t rsp,
  input  wire sensor_regs_pkg::meas_t    meas_raw [sensor_regs_pkg::NCH],
  input  wire sensor_regs_pkg::range_t   meas_lim [sensor_regs_pkg::NCH],
  input  wire logic [3:0]                status_events,
  input  wire logic                      crit_error
);
  import sensor_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0] sel_reg [NSEL];
  logic [15:0] sel_next [NSEL];
  logic [15:0] status_reg;
  logic [15:0] status_next;
  reg_rsp_t    rsp_reg;
  reg_rsp_t    rsp_next;
  meas_arr_t   meas_q;
  src_t        slot [NSLOT];
  logic        req_rd;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word that a source entry yields; float pairs go low half first
  function automatic logic [15:0] word_of(
    input src_t        s,
    input meas_arr_t   m,
    input logic [15:0] st
  );
    logic [15:0] w;
    w = 16'h0000;
    unique case (s.kind)
      SRC_FLO:  w = m[s.idx].fval[15:0];
      SRC_FHI:  w = m[s.idx].fval[31:16];
      SRC_INT:  w = m[s.idx].ival;
      SRC_STAT: w = st;
      SRC_NONE: w = 16'h0000;
    endcase
    return w;
  endfunction

  // Address window tests, all in protocol addresses
  function automatic logic in_range(
    input logic [15:0] a,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    return (a >= lo) && (a <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Per-channel clamp and fault substitution; one cycle of latency
  // keeps every register read served from flops, never from pins.

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    meas_clamp u_clamp (
      .mclk       (mclk),
      .nrst       (nrst),
      .raw        (meas_raw[c]),
      .lim        (meas_lim[c]),
      .crit_error (crit_error),
      .meas_q     (meas_q[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Window layout follows the selectors straight away, so a selector
  // write is visible to the very next read.

  custom_slot_map u_slots (
    .mclk (mclk),
    .nrst (nrst),
    .sel  (sel_reg),
    .slot (slot)
  );

  ////////////////////////////////////////////////////////////////////////
  // Status flags: a level image of the event inputs, not sticky, so a
  // flag drops on the first clock edge after its event goes away.

  always_comb begin
    status_next = 16'h0000;
    status_next[ST_NOT_ADJ]     = status_events[ST_NOT_ADJ];
    status_next[ST_PRESS_FAULT] = status_events[ST_PRESS_FAULT];
    status_next[ST_DISP_COMM]   = status_events[ST_DISP_COMM];
    status_next[ST_AZ_FAIL]     = status_events[ST_AZ_FAIL];
  end

  always_ff @(posedge mclk) begin
    if (!nrst) status_reg <= 16'h0000;
    else status_reg <= status_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Request decode. One register per request; the protocol engine in
  // front splits block transfers, which keeps this path single cycle.

  always_comb begin
    src_t       s;
    logic       rd;
    logic       wr;
    logic [4:0] win_off;
    logic [3:0] sel_off;
    s        = classify(req.addr);
    rd       = (req.func == FC_RD_HOLD) || (req.func == FC_RD_INPUT);
    wr       = (req.func == FC_WR_MULTI);
    win_off  = 5'(req.addr - WIN_FIRST);
    sel_off  = 4'(req.addr - SEL_FIRST);
    sel_next = sel_reg;
    rsp_next = '0;
    if (req.valid) begin
      rsp_next.valid = 1'b1;
      if (rd) begin
        if (in_range(req.addr, WIN_FIRST, WIN_LAST)) begin
          rsp_next.rdata = word_of(slot[win_off], meas_q, status_reg);
        end else if (in_range(req.addr, SEL_FIRST, SEL_LAST)) begin
          rsp_next.rdata = sel_reg[sel_off];
        end else if (s.kind != SRC_NONE) begin
          rsp_next.rdata = word_of(s, meas_q, status_reg);
        end else begin
          rsp_next.err = 1'b1;
          rsp_next.exc = EXC_ADDR;
        end
      end else if (wr) begin
        if (in_range(req.addr, SEL_FIRST, SEL_LAST)) begin
          sel_next[sel_off] = req.wdata;
        end else begin
          // Only the selector block is writable
          rsp_next.err = 1'b1;
          rsp_next.exc = EXC_ADDR;
        end
      end else begin
        rsp_next.err = 1'b1;
        rsp_next.exc = EXC_FUNC;
      end
    end
  end

  // Selectors reset to empty so the window reads zero until configured
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < NSEL; i++) sel_reg[i] <= SEL_RESET;
      rsp_reg <= '0;
    end else begin
      for (int i = 0; i < NSEL; i++) sel_reg[i] <= sel_next[i];
      rsp_reg <= rsp_next;
    end
  end

  assign rsp = rsp_reg;

  // Either read function code; used only by the checks below
  assign req_rd = req.valid && (req.func == FC_RD_HOLD || req.func == FC_RD_INPUT);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  status_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req.valid && req.func == FC_RD_HOLD && req.addr == STATUS_ADDR) |=>
      (rsp.valid && !rsp.err && rsp.rdata == $past(status_reg)))
    else $error("status read does not match flags");

  status_bits_a: assert property (@(posedge mclk) disable iff (!nrst)
    ##1 status_reg[ST_BITS - 1:0] == $past(status_events) &&
      status_reg[15:ST_BITS] == 12'h000)
    else $error("status flags not tracking events");

  word_low_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req_rd && req.addr == FLOAT_BASE[CH_PA]) |=>
      rsp.rdata == $past(meas_q[CH_PA].fval[15:0]))
    else $error("first float word is not the low mantissa");

  word_high_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req_rd && req.addr == FLOAT_BASE[CH_PA] + 16'h0001) |=>
      rsp.rdata == $past(meas_q[CH_PA].fval[31:16]))
    else $error("second float word is not sign and exponent");

  sel_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req.valid && req.func == FC_WR_MULTI && req.addr == SEL_FIRST) |=>
      (sel_reg[0] == $past(req.wdata) && rsp.valid && !rsp.err))
    else $error("selector write not stored");

  sel_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req_rd && req.addr == SEL_LAST) |=>
      (rsp.valid && !rsp.err && rsp.rdata == $past(sel_reg[NSEL - 1])))
    else $error("selector read back wrong");

  // A refused write must leave the last selector untouched
  sel_refuse_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req.valid && req.func == FC_WR_MULTI && !in_range(req.addr, SEL_FIRST, SEL_LAST)) |=>
      (rsp.err && rsp.exc == EXC_ADDR && sel_reg[NSEL - 1] == $past(sel_reg[NSEL - 1])))
    else $error("write outside selectors not refused");

  write_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req.valid && req.func == FC_WR_MULTI) |=> (rsp.valid && rsp.rdata == 16'h0000))
    else $error("write answer carries data");

  addr_refuse_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req_rd && classify(req.addr).kind == SRC_NONE &&
     !in_range(req.addr, WIN_FIRST, WIN_LAST) && !in_range(req.addr, SEL_FIRST, SEL_LAST)) |=>
      (rsp.valid && rsp.err && rsp.exc == EXC_ADDR))
    else $error("unmapped read not refused");

  // The answer is a one-cycle pulse; nothing shows without a request
  rsp_idle_a: assert property (@(posedge mclk) disable iff (!nrst)
    !req.valid |=> rsp == '0)
    else $error("answer without request");

  crit_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    crit_error ##1 (crit_error && req_rd && req.addr == FLOAT_BASE[CH_PA] + 16'h0001) |=>
      rsp.rdata == FLOAT_NAN[31:16])
    else $error("fault value not read back");

  win_int_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req_rd && req.addr == WIN_FIRST && slot[0].kind == SRC_INT) |=>
      rsp.rdata == $past(meas_q[slot[0].idx].ival))
    else $error("integer slot not one word");

  bad_func_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req.valid && req.func != FC_RD_HOLD && req.func != FC_RD_INPUT &&
     req.func != FC_WR_MULTI) |=> (rsp.valid && rsp.err && rsp.exc == EXC_FUNC))
    else $error("illegal function not refused");

  window_ok_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req.valid && req.func == FC_RD_HOLD &&
     in_range(req.addr, WIN_FIRST, WIN_LAST)) |=> (rsp.valid && !rsp.err))
    else $error("window read refused");

  window_empty_a: assert property (@(posedge mclk) disable iff (!nrst)
    (req_rd && in_range(req.addr, WIN_FIRST, WIN_LAST) &&
     slot[5'(req.addr - WIN_FIRST)].kind == SRC_NONE) |=> rsp.rdata == 16'h0000)
    else $error("empty slot not zero");

endmodule
`default_nettype wire

// ### testbench/modbus_master_model.sv
// Serial bus master stand-in that issues one register access at a time
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
  input  wire logic                      mclk,
  output var  sensor_regs_pkg::reg_req_t req,
  input  wire sensor_regs_pkg::reg_rsp_t rsp
);
  import sensor_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus idle from time zero
  initial begin
    req = '0;
  end

  // Request launched just after an edge and held until the edge that takes it
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w,
                      output reg_rsp_t r);
    @(posedge mclk);
    #1;
    req = '{valid: 1'b1, func: f, addr: a, wdata: w};
    @(posedge mclk);
    #1;
    r = rsp;
    // Released fields flip, so the design cannot lean on stale request data
    req = '{valid: 1'b0, func: ~f, addr: ~a, wdata: ~w};
  endtask

  // The master rebuilds a float by putting the second word on top
  function automatic logic [31:0] join_words(input logic [15:0] lo, input logic [15:0] hi);
    return {hi, lo};
  endfunction
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the sensor register map
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sensor_regs_pkg::*;

  logic        mclk;
  logic        nrst;
  reg_req_t    req;
  reg_rsp_t    rsp;
  meas_t       meas_raw [NCH];
  range_t      meas_lim [NCH];
  logic [3:0]  status_events;
  logic        crit_error;
  reg_rsp_t    r;
  logic [15:0] lo_word;
  logic [31:0] joined;
  int          fails;
  int          comparisons;

  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  sensor_modbus_register_map dut_u (
    .mclk(mclk), .nrst(nrst), .req(req), .rsp(rsp), .meas_raw(meas_raw),
    .meas_lim(meas_lim), .status_events(status_events), .crit_error(crit_error));

  modbus_master_model master_u (.mclk(mclk), .req(req), .rsp(rsp));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare helpers and bus tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // A read must answer clean with the expected word
  task automatic rd(input logic [7:0] f, input logic [15:0] a, input logic [15:0] exp);
    master_u.xfer(f, a, 16'h0000, r);
    check({r.valid, r.err, 14'h0000}, 16'h8000);
    check(r.rdata, exp);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] w);
    master_u.xfer(FC_WR_MULTI, a, w, r);
    check({r.valid, r.err, r.rdata[13:0]}, 16'h8000);
  endtask

  // Refused access: exception flag and code
  task automatic bad(input logic [7:0] f, input logic [15:0] a, input logic [7:0] exc);
    master_u.xfer(f, a, 16'h0001, r);
    check({r.valid, r.err, 6'h00, r.exc}, {2'b11, 6'h00, exc});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(2000 * 25);
    fails++;
    tally_and_finish;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    fails = 0;
    comparisons = 0;
    nrst = 1'b0;
    status_events = 4'h0;
    crit_error = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      meas_raw[i] = '{fval: {16'h4000 + 16'(i), 16'h0100 * 16'(i)}, ival: 16'h0010 + 16'(i)};
      meas_lim[i] = '{flo: 32'h00000000, fhi: 32'h461C4000, ilo: 16'h0000, ihi: 16'h2710};
    end
    meas_raw[2] = '{fval: 32'h43F8FBA5, ival: 16'h01F2};
    repeat (16) @(posedge mclk);
    #1;
    nrst = 1'b1;
    idle(2);
    check({15'h0000, rsp.valid}, 16'h0000);
    // Float pair: low mantissa word, then sign and exponent word
    rd(FC_RD_HOLD, 16'd1215 - 16'd1, 16'hFBA5);
    lo_word = r.rdata;
    rd(FC_RD_INPUT, 16'h04BF, 16'h43F8);
    joined = master_u.join_words(lo_word, r.rdata);
    check(joined[31:16], 16'h43F8);
    check(joined[15:0], 16'hFBA5);
    rd(FC_RD_HOLD, 16'd4108 - 16'd1, 16'h01F2);
    idle(1);
    check({15'h0000, rsp.valid}, 16'h0000);
    // Out of range high, then low
    meas_raw[2] = '{fval: 32'h47000000, ival: 16'h4000};
    idle(2);
    rd(FC_RD_HOLD, 16'h04BF, 16'h461C);
    rd(FC_RD_HOLD, 16'h100B, 16'h2710);
    meas_raw[2] = '{fval: 32'hBF800000, ival: 16'hFF00};
    idle(2);
    rd(FC_RD_HOLD, 16'h04BF, 16'h0000);
    rd(FC_RD_INPUT, 16'h100B, 16'h0000);
    meas_raw[2] = '{fval: 32'h43F8FBA5, ival: 16'h01F2};
    // Each status flag alone
    for (int b = 0; b < ST_BITS; b++) begin
      status_events = 4'h1 << b;
      idle(2);
      rd(FC_RD_INPUT, STATUS_ADDR, 16'h0001 << b);
    end
    status_events = 4'h0;
    idle(2);
    rd(FC_RD_HOLD, STATUS_ADDR, 16'h0000);
    // Mixed custom map: integer, two floats, rest empty
    wr(16'h1770, 16'h100B);
    wr(16'h1771, 16'h041E);
    wr(16'h1772, 16'h0410);
    rd(FC_RD_HOLD, 16'h1771, 16'h041E);
    rd(FC_RD_HOLD, 16'h0BB8, 16'h01F2);
    rd(FC_RD_HOLD, 16'h0BB9, meas_raw[7].fval[15:0]);
    rd(FC_RD_HOLD, 16'h0BBA, meas_raw[7].fval[31:16]);
    rd(FC_RD_INPUT, 16'h0BBB, meas_raw[5].fval[15:0]);
    rd(FC_RD_INPUT, 16'h0BBC, meas_raw[5].fval[31:16]);
    rd(FC_RD_INPUT, 16'h0BBD, 16'h0000);
    // Ten float selections fill all twenty slots
    for (int k = 0; k < NSEL; k++) begin
      wr(SEL_FIRST + 16'(k), FLOAT_BASE[k]);
    end
    for (int s = 0; s < NSLOT; s++) begin
      lo_word = s[0] ? meas_raw[s / 2].fval[31:16] : meas_raw[s / 2].fval[15:0];
      rd(FC_RD_HOLD, WIN_FIRST + 16'(s), lo_word);
    end
    bad(FC_RD_HOLD, WIN_LAST + 16'h0001, EXC_ADDR);
    bad(FC_WR_MULTI, SEL_LAST + 16'h0001, EXC_ADDR);
    bad(8'h06, SEL_FIRST, EXC_FUNC);
    rd(FC_RD_HOLD, SEL_LAST, FLOAT_BASE[9]);
    // Critical fault substitutes every measurement
    crit_error = 1'b1;
    idle(2);
    rd(FC_RD_HOLD, 16'h04BE, 16'h0000);
    rd(FC_RD_HOLD, 16'h04BF, 16'h7FC0);
    rd(FC_RD_INPUT, 16'h0FC7, 16'h8000);
    rd(FC_RD_INPUT, 16'h0BCB, 16'h7FC0);
    crit_error = 1'b0;
    idle(2);
    rd(FC_RD_HOLD, 16'h04BE, 16'hFBA5);
    // Mid-run reset must empty the selectors and so the window
    nrst = 1'b0;
    idle(2);
    nrst = 1'b1;
    idle(2);
    rd(FC_RD_HOLD, SEL_FIRST, SEL_RESET);
    rd(FC_RD_INPUT, WIN_FIRST, 16'h0000);
    rd(FC_RD_HOLD, WIN_LAST, 16'h0000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
